// ---- verilog/pptr_core_tx.sv ----
// The placing of the registers and the AHB-Lite register port were decided locally.
`include "pptr_consts.svh"

// How it works
// (RL1) One flow carries data PDUs, subchannel PDUs and message blocks mixed.
// (RL2) The remote node makes timestamp blocks; this sender never sends them.
// (RL3) A prepended 32-bit timestamp names exactly one link-channel frame.
// (RL4) Timestamped blocks are sent 1 to 20 frame durations early.
// (RL5) The remote node may drop blocks outside that advance window.
// (RL6) Trigger blocks leave in their intended transmission order.
// (RL7) Trigger blocks always carry a prepended timestamp.
// (RL8) Untimestamped blocks get a frame chosen by the remote node.
// (RL9) Emergency blocks go in order and always carry a timestamp.
// (RL10) The remote node keeps arrival order of emergency blocks per frame.
// (RL11) Generic types 5-15 on 4K FFT: body at most 343, 348 total.
// (RL12) Generic types 5-15 may go with or without timestamp.
// (RL13) Link-channel traffic is throttled to the rate the channel carries.
// (RL14) Timestamped bytes per frame stay within capacity less timestamp block.
// (RL15) The remote node supports four, optionally eight, flows per session.
// (RL16) Each segment carries an 8-bit channel identifier, up to 256 channels.
// (RL17) Channel identifiers stay below the session's channel count N.
// (RL18) The remote node carries its maximum single-carrier channels per port.
// (RL19) The remote node handles at least 8 multi-channel sessions per port.
// (RL20) Each OFDM channel is one session: data channel plus link subchannel.
// (RL21) Each segment carries its own profile and channel identifier.
// (RL22) All segments of one PDU finish before the next PDU on a flow.
// (RL23) On the link subchannel, profile bit 0 set marks a message block.
// (RL24) Timestamp precedes a block exactly when segment-type and begin are 1.
// (RL25) The remote node computes and inserts the 24-bit block CRC.
// (RL26) The remote node queues timestamped blocks until their frame begins.
module pptr_core_tx
  import pptr_pkg::*;
#(
  parameter int MB_WORDS     = `PPTR_MB_WORDS,
  parameter int FRAME_CYCLES = `PPTR_FRAME_CYCLES,
  parameter int FRAME_CAP    = `PPTR_FRAME_CAP
) (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave for the command and status registers.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Segment stream toward the remote node.
  output logic             seg_valid,
  input  wire logic        seg_ready,
  output logic             seg_sop,
  output logic             seg_eop,
  output logic [31:0]      seg_data,
  output logic [7:0]       seg_chan_id,
  output logic [3:0]       seg_profile,
  output logic             seg_begin,
  output logic             seg_end,
  output logic [2:0]       seg_flow,
  output logic [3:0]       seg_chan_seq,
  output logic [13:0]      seg_len
);
  localparam int PW = $clog2(MB_WORDS + 1);

  // Whole state of the sender apart from the frame scheduler's, including the block buffer.
  typedef struct packed {
    pptr_state_t               st;
    logic                      fft4k;
    logic [8:0]                nch;
    logic [31:0]               cmd;
    logic [13:0]               len;
    logic [MB_WORDS-1:0][31:0] mem;
    logic [PW-1:0]             wr_ptr;
    logic [PW-1:0]             rd_ptr;
    logic [3:0]                cause;
    logic [255:0][3:0]         seq;
    logic                      dp_wr;
    logic [7:0]                dp_ofs;
    logic [31:0]               rdata;
    logic                      vld;
    logic                      sop;
    logic                      eop;
    logic [31:0]               data;
    logic [7:0]                chan;
    logic [3:0]                prof;
    logic                      bgn;
    logic                      fin;
    logic [2:0]                flow;
    logic [3:0]                cseq;
    logic [13:0]               slen;
  } pptr_core_st_t;

  pptr_core_st_t st_ff;
  pptr_core_st_t nxt_st;

  // Fields of the command on the write bus and of the held command.
  logic [7:0]  c_chan;
  logic        c_mb;
  logic        c_ts;
  logic [4:0]  c_adv;
  logic [3:0]  c_type;
  logic [3:0]  c_cause;
  logic [7:0]  h_chan;
  logic        h_mb;
  logic        h_ts;
  logic [13:0] nwords;
  logic [13:0] tx_size;
  logic [31:0] tgt_ts;
  logic [31:0] frame_ts;
  logic        fit_ok;
  logic        go_ok;
  logic        commit;
  logic [31:0] rd_val;

  assign c_chan  = hwdata[`PPTR_CMD_CHAN +: 8]; // [RL16]
  assign c_mb    = hwdata[`PPTR_CMD_MB];
  assign c_ts    = hwdata[`PPTR_CMD_TS];
  assign c_adv   = hwdata[`PPTR_CMD_ADV +: 5];
  assign c_type  = hwdata[`PPTR_CMD_TYPE +: 4];
  assign h_chan  = st_ff.cmd[`PPTR_CMD_CHAN +: 8];
  assign h_mb    = st_ff.cmd[`PPTR_CMD_MB];
  assign h_ts    = st_ff.cmd[`PPTR_CMD_TS];
  assign nwords  = (st_ff.len + 14'h0003) >> 2;
  assign tx_size = h_ts ? st_ff.len + `PPTR_TS_BYTES : st_ff.len;

  // Frame timing, per-frame budget and rate credit.
  pptr_frame_sched #(
    .FRAME_CYCLES (FRAME_CYCLES),
    .FRAME_CAP    (FRAME_CAP)
  ) u_sched (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .adv       (st_ff.cmd[`PPTR_CMD_ADV +: 5]),
    .size      (tx_size),
    .ts_en     (h_ts),
    .commit    (commit),
    .frame_ts  (frame_ts),
    .target_ts (tgt_ts),
    .fit_ok    (fit_ok),
    .go_ok     (go_ok)
  );

  // Check a command before it is queued; the first failing check is
  // reported, so software sees one cause at a time.
  always_comb begin
    c_cause = `PPTR_CAUSE_NONE;
    if (st_ff.st != st_idle) begin
      c_cause = `PPTR_CAUSE_BUSY; // [RL6] [RL9] [RL22]
    end else if ({1'b0, c_chan} >= st_ff.nch) begin
      c_cause = `PPTR_CAUSE_CHAN; // [RL17]
    end else if (st_ff.len == 14'h0000 || nwords > 14'(MB_WORDS) ||
                 nwords > 14'(st_ff.wr_ptr)) begin
      c_cause = `PPTR_CAUSE_LEN;
    end else if (c_mb && c_ts &&
                 (c_adv < `PPTR_ADV_MIN || c_adv > `PPTR_ADV_MAX)) begin
      c_cause = `PPTR_CAUSE_ADV; // [RL4]
    end else if (c_mb && !c_ts && (c_type == `PPTR_TYPE_TRIG ||
                 c_type == `PPTR_TYPE_EMERG)) begin
      c_cause = `PPTR_CAUSE_NOTS; // [RL7] [RL9]
    end else if (c_mb && st_ff.fft4k && c_type >= `PPTR_TYPE_GEN_LO &&
                 st_ff.len > `PPTR_GEN_BODY + `PPTR_MB_HDR) begin
      c_cause = `PPTR_CAUSE_SIZE; // [RL11]
    end
  end

  // Read multiplexer, sampled in the address phase.
  always_comb begin
    rd_val = 32'h0000_0000;
    case (haddr[7:0])
      `PPTR_OFS_CTRL: begin
        rd_val[`PPTR_CTRL_FFT4K]    = st_ff.fft4k;
        rd_val[`PPTR_CTRL_NCH +: 9] = st_ff.nch;
      end
      `PPTR_OFS_CMD: begin
        rd_val = st_ff.cmd;
      end
      `PPTR_OFS_LEN: begin
        rd_val[13:0] = st_ff.len;
      end
      `PPTR_OFS_STAT: begin
        rd_val[`PPTR_STAT_BUSY]       = st_ff.st != st_idle;
        rd_val[`PPTR_STAT_VLD]        = st_ff.vld;
        rd_val[`PPTR_STAT_CAUSE +: 4] = st_ff.cause;
        rd_val[`PPTR_STAT_WPTR +: PW] = st_ff.wr_ptr;
      end
      `PPTR_OFS_FRAME: begin
        rd_val = frame_ts;
      end
      default: begin
        rd_val = 32'h0000_0000;
      end
    endcase
  end

  // Next state: bus slave, command intake and segment sender.
  always_comb begin
    nxt_st = st_ff;
    commit = 1'b0;
    // Address phase; only whole-word transfers are acted upon.
    nxt_st.dp_wr = 1'b0;
    if (hsel && hready && htrans[1] && hsize == 3'h2) begin
      nxt_st.dp_wr  = hwrite;
      nxt_st.dp_ofs = haddr[7:0];
      if (!hwrite) begin
        nxt_st.rdata = rd_val;
      end
    end
    // Data phase of a write.
    if (st_ff.dp_wr) begin
      case (st_ff.dp_ofs)
        `PPTR_OFS_CTRL: begin
          nxt_st.fft4k = hwdata[`PPTR_CTRL_FFT4K];
          nxt_st.nch   = hwdata[`PPTR_CTRL_NCH +: 9];
        end
        `PPTR_OFS_LEN: begin
          // A new length starts a new block; ignored while one is in flight.
          if (st_ff.st == st_idle) begin
            nxt_st.len    = hwdata[13:0];
            nxt_st.wr_ptr = '0;
          end
        end
        `PPTR_OFS_DATA: begin
          if (st_ff.st == st_idle && st_ff.wr_ptr < PW'(MB_WORDS)) begin
            nxt_st.mem[st_ff.wr_ptr] = hwdata;
            nxt_st.wr_ptr            = st_ff.wr_ptr + PW'(1);
          end
        end
        `PPTR_OFS_CMD: begin
          nxt_st.cause = c_cause;
          if (c_cause == `PPTR_CAUSE_NONE) begin
            nxt_st.cmd = hwdata;
            // A PDU never carries a timestamp word.
            nxt_st.cmd[`PPTR_CMD_TS] = c_mb && c_ts; // [RL12]
            nxt_st.st  = st_wait;
          end
        end
        default: begin
        end
      endcase
    end
    // Sender; one block at a time keeps every kind in command order.
    unique case (st_ff.st)
      st_idle: begin
      end
      st_wait: begin
        if (h_ts && !fit_ok) begin
          nxt_st.cause = `PPTR_CAUSE_FULL; // [RL14]
          nxt_st.st    = st_idle;
        end else if (go_ok) begin
          commit      = 1'b1; // [RL13]
          nxt_st.vld  = 1'b1;
          nxt_st.sop  = 1'b1;
          nxt_st.chan = h_chan; // [RL21]
          // Block segments set the type bit; PDUs keep their own profile.
          nxt_st.prof = h_mb ? `PPTR_PROF_MB :
                        st_ff.cmd[`PPTR_CMD_PROF +: 4]; // [RL23] [RL1]
          nxt_st.bgn  = h_mb ? h_ts : 1'b1; // [RL24]
          nxt_st.fin  = 1'b1; // [RL22]
          nxt_st.flow = st_ff.cmd[`PPTR_CMD_FLOW +: 3];
          nxt_st.cseq = st_ff.seq[h_chan];
          nxt_st.seq[h_chan] = st_ff.seq[h_chan] + 4'h1;
          nxt_st.slen = tx_size;
          nxt_st.st   = st_send;
          if (h_ts) begin
            nxt_st.data   = tgt_ts; // [RL3] [RL4]
            nxt_st.rd_ptr = '0;
            nxt_st.eop    = 1'b0;
          end else begin
            nxt_st.data   = st_ff.mem[0];
            nxt_st.rd_ptr = PW'(1);
            nxt_st.eop    = nwords == 14'h0001;
          end
        end
      end
      st_send: begin
        if (seg_ready) begin
          if (st_ff.eop) begin
            nxt_st.vld    = 1'b0;
            nxt_st.sop    = 1'b0;
            nxt_st.eop    = 1'b0;
            nxt_st.wr_ptr = '0;
            nxt_st.st     = st_idle;
          end else begin
            nxt_st.data   = st_ff.mem[st_ff.rd_ptr];
            nxt_st.rd_ptr = st_ff.rd_ptr + PW'(1);
            nxt_st.sop    = 1'b0;
            nxt_st.eop    = 14'(st_ff.rd_ptr) + 14'h0001 == nwords;
          end
        end
      end
      default: begin
        nxt_st.st = st_idle;
      end
    endcase
  end

  // State register; the session defaults to a data/subchannel pair.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff     <= '0;
      st_ff.st  <= st_idle;
      st_ff.nch <= `PPTR_NCH_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Bus answers with no wait state and never an error.
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = st_ff.rdata;
  // Segment outputs all come straight from the state register.
  assign seg_valid    = st_ff.vld;
  assign seg_sop      = st_ff.sop;
  assign seg_eop      = st_ff.eop;
  assign seg_data     = st_ff.data;
  assign seg_chan_id  = st_ff.chan;
  assign seg_profile  = st_ff.prof;
  assign seg_begin    = st_ff.bgn;
  assign seg_end      = st_ff.fin;
  assign seg_flow     = st_ff.flow;
  assign seg_chan_seq = st_ff.cseq;
  assign seg_len      = st_ff.slen;

endmodule // pptr_core_tx

// ---- verilog/pptr_consts.svh ----
`ifndef PPTR_CONSTS_SVH
`define PPTR_CONSTS_SVH

// Register byte offsets of the command and status block.
`define PPTR_OFS_CTRL    8'h00
`define PPTR_OFS_CMD     8'h04
`define PPTR_OFS_LEN     8'h08
`define PPTR_OFS_DATA    8'h0C
`define PPTR_OFS_STAT    8'h10
`define PPTR_OFS_FRAME   8'h14

// Control register fields and reset value of the session size.
`define PPTR_CTRL_FFT4K  0
`define PPTR_CTRL_NCH    8
`define PPTR_NCH_RESET   9'h002

// Command register fields.
`define PPTR_CMD_CHAN    0
`define PPTR_CMD_PROF    8
`define PPTR_CMD_MB      12
`define PPTR_CMD_TS      13
`define PPTR_CMD_ADV     14
`define PPTR_CMD_TYPE    19
`define PPTR_CMD_FLOW    23

// Status register fields.
`define PPTR_STAT_BUSY   0
`define PPTR_STAT_VLD    1
`define PPTR_STAT_CAUSE  4
`define PPTR_STAT_WPTR   8

// Refusal causes reported in the status register.
`define PPTR_CAUSE_NONE  4'h0
`define PPTR_CAUSE_BUSY  4'h1
`define PPTR_CAUSE_CHAN  4'h2
`define PPTR_CAUSE_LEN   4'h3
`define PPTR_CAUSE_ADV   4'h4
`define PPTR_CAUSE_NOTS  4'h5
`define PPTR_CAUSE_SIZE  4'h6
`define PPTR_CAUSE_FULL  4'h7

// Message block limits and codes.
`define PPTR_ADV_MIN     5'h01
`define PPTR_ADV_MAX     5'h14
`define PPTR_TYPE_TRIG   4'h3
`define PPTR_TYPE_EMERG  4'h4
`define PPTR_TYPE_GEN_LO 4'h5
`define PPTR_GEN_BODY    14'h157
`define PPTR_MB_HDR      14'h005
`define PPTR_PROF_MB     4'h1
`define PPTR_TS_BYTES    14'h0004

// Sizing and timing defaults.
`define PPTR_MB_WORDS      128
`define PPTR_FRAME_CYCLES  32'h7D0
`define PPTR_FRAME_CAP     16'h0200
`define PPTR_TS_MB_BYTES   16'h0008
`define PPTR_CREDIT_MAX    16'h0800

`endif

// ---- verilog/pptr_pkg.sv ----
package pptr_pkg;

  // Sender sequence, one-hot.
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_wait = 3'b010,
    st_send = 3'b100
  } pptr_state_t;

endpackage : pptr_pkg

// ---- verilog/pptr_frame_sched.sv ----
`include "pptr_consts.svh"

module pptr_frame_sched
  import pptr_pkg::*;
#(
  parameter int FRAME_CYCLES = `PPTR_FRAME_CYCLES,
  parameter int FRAME_CAP    = `PPTR_FRAME_CAP
) (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Request under test and its commit strobe.
  input  wire logic [4:0]  adv,
  input  wire logic [13:0] size,
  input  wire logic        ts_en,
  input  wire logic        commit,
  // Frame time and verdicts.
  output logic [31:0]      frame_ts,
  output logic [31:0]      target_ts,
  output logic             fit_ok,
  output logic             go_ok
);
  localparam int CW = $clog2(FRAME_CYCLES);
  localparam logic [15:0] LIMIT = 16'(FRAME_CAP) - `PPTR_TS_MB_BYTES;

  typedef struct packed {
    logic [CW-1:0]     cyc;
    logic [31:0]       base;
    logic [4:0]        idx;
    logic [15:0]       credit;
    logic [31:0][15:0] used;
  } pptr_sched_st_t;

  pptr_sched_st_t st_ff;
  pptr_sched_st_t nxt_st;
  logic           tick;
  logic [4:0]     tidx;
  logic [16:0]    refill;

  // A target frame is named by its start time, so one value maps to
  // exactly one frame.
  assign tick      = st_ff.cyc == CW'(FRAME_CYCLES - 1);
  assign tidx      = st_ff.idx + adv;
  assign frame_ts  = st_ff.base;
  assign target_ts = st_ff.base + 32'(adv) * 32'(FRAME_CYCLES); // [RL3]
  assign fit_ok    = (16'(size) + st_ff.used[tidx]) <= LIMIT; // [RL14]
  // Commits wait out the frame edge so the advance never shrinks by one.
  assign go_ok     = !tick && st_ff.credit >= 16'(size); // [RL13]
  assign refill    = {1'b0, st_ff.credit} + 17'(FRAME_CAP);

  // Frame counter, per-frame byte table and rate credit.
  always_comb begin
    nxt_st = st_ff;
    if (tick) begin
      nxt_st.cyc            = '0;
      nxt_st.base           = st_ff.base + 32'(FRAME_CYCLES);
      nxt_st.idx            = st_ff.idx + 5'h01;
      // The ending frame's slot is reused 32 frames on, beyond any advance.
      nxt_st.used[st_ff.idx] = 16'h0000;
      if (refill > {1'b0, `PPTR_CREDIT_MAX}) begin
        nxt_st.credit = `PPTR_CREDIT_MAX;
      end else begin
        nxt_st.credit = refill[15:0];
      end
    end else begin
      nxt_st.cyc = st_ff.cyc + CW'(1);
    end
    if (commit) begin
      nxt_st.credit = st_ff.credit - 16'(size); // [RL13]
      if (ts_en) begin
        nxt_st.used[tidx] = st_ff.used[tidx] + 16'(size); // [RL14]
      end
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule // pptr_frame_sched

// ---- verification/pptr_core_tx_assertions.sv ----
`include "pptr_consts.svh"

module pptr_core_tx_checker
  import pptr_pkg::*;
#(
  parameter int FRAME_CYCLES = 64
) (
  // Clock and reset.
  input wire logic        hclk,
  input wire logic        hresetn,
  // Register bus.
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Segment stream.
  input wire logic        seg_valid,
  input wire logic        seg_ready,
  input wire logic        seg_sop,
  input wire logic        seg_eop,
  input wire logic [31:0] seg_data,
  input wire logic [7:0]  seg_chan_id,
  input wire logic [3:0]  seg_profile,
  input wire logic        seg_begin,
  input wire logic        seg_end,
  input wire logic [2:0]  seg_flow,
  input wire logic [13:0] seg_len
);
  logic [8:0]  nch_ff;
  logic        cw_ff;
  logic [31:0] cyc_ff;
  logic [13:0] wc_ff;

  // Session size is tracked off the bus, so no internal probe is needed.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nch_ff <= `PPTR_NCH_RESET;
      cw_ff  <= 1'b0;
      cyc_ff <= 32'h0;
      wc_ff  <= 14'h0;
    end else begin
      cw_ff <= hsel && hready && htrans[1] && hwrite && hsize == 3'h2
               && haddr[7:0] == `PPTR_OFS_CTRL;
      if (cw_ff) nch_ff <= hwdata[16:8];
      if (cyc_ff < FRAME_CYCLES) cyc_ff <= cyc_ff + 32'h1;
      if (seg_valid && seg_ready) wc_ff <= seg_eop ? 14'h0 : wc_ff + 14'h1;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // A word taken inside a segment, and the closing word.
  sequence s_mid;
    seg_valid && seg_ready && !seg_eop;
  endsequence
  sequence s_last;
    seg_valid && seg_ready && seg_eop;
  endsequence

  word_hold_a: assert property (
    seg_valid && !seg_ready |=> seg_valid && $stable(seg_data)
      && $stable(seg_sop) && $stable(seg_eop))
    else $error("Word changed while held.");
  hdr_stable_a: assert property (
    s_mid |=> seg_valid && !seg_sop && $stable(seg_chan_id)
      && $stable(seg_profile) && $stable(seg_flow) && $stable(seg_len))
    else $error("Header changed in segment.");
  next_sop_a: assert property (s_last |=> !seg_valid || seg_sop)
    else $error("Segment began without start.");
  word_count_a: assert property (
    s_last |-> wc_ff + 14'h1 == (seg_len + 14'h3) >> 2)
    else $error("Word count off segment length.");
  chan_range_a: assert property (
    seg_valid |-> {1'b0, seg_chan_id} < nch_ff)
    else $error("Channel not below session size.");
  pdu_begin_a: assert property (
    seg_valid && !seg_begin |-> seg_profile == `PPTR_PROF_MB)
    else $error("Segment without begin flag is not a block.");
  one_seg_a: assert property (seg_valid |-> seg_end)
    else $error("Unit split over several segments.");
  credit_start_a: assert property (
    cyc_ff < FRAME_CYCLES - 1 |-> !seg_valid)
    else $error("Segment before rate credit.");
  bus_okay_a: assert property (hsel && htrans[1] |=> hreadyout && !hresp)
    else $error("Bus answer not ready and okay.");
endmodule : pptr_core_tx_checker

bind pptr_core_tx pptr_core_tx_checker #(.FRAME_CYCLES(FRAME_CYCLES))
  i_chk (.*);

// ---- verification/pptr_node_model.sv ----
module pptr_node_model (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Slow mode: ready toggles every cycle.
  input  wire logic        stall,
  // Segment stream from the sender.
  input  wire logic        seg_valid,
  output logic             seg_ready,
  input  wire logic        seg_sop,
  input  wire logic [31:0] seg_data,
  input  wire logic [7:0]  seg_chan_id,
  input  wire logic [3:0]  seg_profile,
  input  wire logic        seg_begin,
  input  wire logic [2:0]  seg_flow,
  input  wire logic [3:0]  seg_chan_seq,
  input  wire logic [13:0] seg_len
);
  logic [29:0] hdr_q[$];
  logic [3:0]  seq_q[$];
  logic [31:0] word_q[$];
  logic [31:0] ts_q[$];

  // Ready is changed just after the edge, like any real receiver.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) seg_ready <= 1'b0;
    else seg_ready <= stall ? ~seg_ready : 1'b1;
  end

  // Node's own: stamps, CRC, ports.
  // Blocks kept in arrival order, none dropped.
  always @(posedge hclk) begin
    if (hresetn && seg_valid && seg_ready) begin
      // Any flow, channel and profile is taken.
      if (seg_sop) begin
        hdr_q.push_back({seg_chan_id, seg_profile, seg_begin, seg_flow,
                         seg_len});
        seq_q.push_back(seg_chan_seq);
      end
      // Lead word is a timestamp only if begin is set.
      if (seg_sop && seg_profile[0] && seg_begin) ts_q.push_back(seg_data);
      else word_q.push_back(seg_data);
    end
  end
endmodule : pptr_node_model

// ---- verification/pptr_core_tx_tb.sv ----
`include "pptr_consts.svh"

module pptr_core_tx_tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int FC = 64;

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, stall;
  logic [31:0] haddr, hwdata, hrdata, seg_data;
  logic [1:0]  htrans;
  logic [2:0]  hsize, seg_flow;
  logic        seg_valid, seg_ready, seg_sop, seg_eop, seg_begin, seg_end;
  logic [7:0]  seg_chan_id;
  logic [3:0]  seg_profile, seg_chan_seq;
  logic [13:0] seg_len;
  int          bad_count = 0;
  int          check_count = 0;

  // Bus clock of 100 ns.
  initial hclk = 1'b0;
  always #50 hclk = ~hclk;

  // Short frames keep the run brief; expectations use FC.
  pptr_core_tx #(.FRAME_CYCLES(FC), .FRAME_CAP(64)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .seg_valid(seg_valid), .seg_ready(seg_ready),
    .seg_sop(seg_sop), .seg_eop(seg_eop), .seg_data(seg_data),
    .seg_chan_id(seg_chan_id), .seg_profile(seg_profile),
    .seg_begin(seg_begin), .seg_end(seg_end), .seg_flow(seg_flow),
    .seg_chan_seq(seg_chan_seq), .seg_len(seg_len));

  pptr_node_model i_node (
    .hclk(hclk), .hresetn(hresetn), .stall(stall),
    .seg_valid(seg_valid), .seg_ready(seg_ready), .seg_sop(seg_sop),
    .seg_data(seg_data), .seg_chan_id(seg_chan_id),
    .seg_profile(seg_profile), .seg_begin(seg_begin),
    .seg_flow(seg_flow), .seg_chan_seq(seg_chan_seq), .seg_len(seg_len));

  // Prints the counts and the verdict, then stops.
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compares the next recorded segment header.
  task automatic chk_hdr(input logic [29:0] e);
    logic [29:0] g;
    g = i_node.hdr_q.size() > 0 ? i_node.hdr_q.pop_front() : 30'h0;
    chk({2'h0, g}, {2'h0, e});
  endtask

  // Waits for hready at an edge; a long wait ends the run.
  task automatic wait_hi;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      results();
    end
  endtask

  // One single word transfer: address phase, then data phase.
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_hi();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_hi();
    rd = hrdata;
  endtask

  function automatic logic [31:0] cmd(input logic [7:0] ch,
    input logic [3:0] pr, input logic mb, input logic ts,
    input logic [4:0] adv, input logic [3:0] ty, input logic [2:0] fl);
    return {6'h00, fl, ty, adv, ts, mb, pr, ch};
  endfunction

  // Loads a unit, launches it, waits until idle and checks the cause.
  task automatic send(input logic [13:0] len, input logic [31:0] c,
                      input logic [3:0] cause);
    logic [31:0] r;
    int n;
    ahb(1'b1, `PPTR_OFS_LEN, {18'h0, len}, r);
    for (int i = 0; i < (len + 3) / 4; i++)
      ahb(1'b1, `PPTR_OFS_DATA, 32'hC0DE0000 + i, r);
    ahb(1'b1, `PPTR_OFS_CMD, c, r);
    n = 0;
    do begin
      ahb(1'b0, `PPTR_OFS_STAT, 32'h0, r);
      n++;
    end while (r[0] !== 1'b0 && n < 400);
    if (r[0] !== 1'b0) begin
      bad_count++;
      results();
    end
    chk({28'h0, r[7:4]}, {28'h0, cause});
  endtask

  task automatic t_reset;
    logic [7:0]  ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
    logic [31:0] r;
    ahb(1'b1, 8'h18, 32'hFFFFFFFF, r);
    for (int i = 0; i < 6; i++) begin
      ahb(1'b0, ofs[i], 32'h0, r);
      chk(r, i == 0 ? 32'h00000200 : 32'h00000000);
    end
  endtask

  task automatic t_ts_block;
    logic [31:0] f, r;
    ahb(1'b0, `PPTR_OFS_FRAME, 32'h0, f);
    send(14'h0008, cmd(8'h01, 4'h0, 1'b1, 1'b1, 5'h01, 4'h3, 3'h2), 4'h0);
    r = i_node.ts_q.size() > 0 ? i_node.ts_q[0] - f : 32'h0;
    chk({31'h0, r == FC || r == 2 * FC}, 32'h1);
    chk_hdr({8'h01, 4'h1, 1'b1, 3'h2, 14'h000C});
    chk(i_node.word_q[0], 32'hC0DE0000);
    chk(i_node.word_q[1], 32'hC0DE0001);
    for (logic [3:0] t = 4'h3; t < 4'h5; t++)
      send(14'h0008, cmd(8'h01, 4'h0, 1'b1, 1'b0, 5'h00, t, 3'h2), 4'h5);
  endtask

  task automatic t_window;
    logic [4:0]  av [3] = '{5'h00, 5'h15, 5'h14};
    logic [3:0]  cs [3] = '{4'h4, 4'h4, 4'h0};
    logic [31:0] r;
    for (int i = 0; i < 3; i++)
      send(14'h0008, cmd(8'h01, 4'h0, 1'b1, 1'b1, av[i], 4'h3, 3'h0), cs[i]);
    send(14'h0008, cmd(8'h02, 4'h0, 1'b1, 1'b1, 5'h01, 4'h3, 3'h0), 4'h2);
    ahb(1'b1, `PPTR_OFS_CTRL, 32'h00010000, r);
    i_node.hdr_q.delete();
    send(14'h0004, cmd(8'hFF, 4'h2, 1'b0, 1'b0, 5'h00, 4'h0, 3'h7), 4'h0);
    chk_hdr({8'hFF, 4'h2, 1'b1, 3'h7, 14'h0004});
    ahb(1'b1, `PPTR_OFS_CTRL, 32'h00000200, r);
  endtask

  task automatic t_full;
    send(14'h003C, cmd(8'h01, 4'h0, 1'b1, 1'b1, 5'h05, 4'h5, 3'h0), 4'h7);
    send(14'h0034, cmd(8'h01, 4'h0, 1'b1, 1'b1, 5'h05, 4'h5, 3'h0), 4'h0);
  endtask

  task automatic t_generic;
    logic [31:0] r;
    ahb(1'b1, `PPTR_OFS_CTRL, 32'h00000201, r);
    send(14'h015D, cmd(8'h01, 4'h0, 1'b1, 1'b0, 5'h00, 4'h5, 3'h0), 4'h6);
    i_node.hdr_q.delete();
    send(14'h015C, cmd(8'h01, 4'h0, 1'b1, 1'b0, 5'h00, 4'hF, 3'h0), 4'h0);
    send(14'h0008, cmd(8'h01, 4'h0, 1'b1, 1'b1, 5'h02, 4'h6, 3'h0), 4'h0);
    chk_hdr({8'h01, 4'h1, 1'b0, 3'h0, 14'h015C});
    chk_hdr({8'h01, 4'h1, 1'b1, 3'h0, 14'h000C});
    ahb(1'b1, `PPTR_OFS_CTRL, 32'h00000200, r);
  endtask

  // Mixed kinds on one flow with a slow receiver.
  task automatic t_mix;
    i_node.hdr_q.delete();
    i_node.seq_q.delete();
    stall <= 1'b1;
    send(14'h0008, cmd(8'h01, 4'h0, 1'b1, 1'b1, 5'h03, 4'h4, 3'h1), 4'h0);
    send(14'h0010, cmd(8'h00, 4'h2, 1'b0, 1'b0, 5'h00, 4'h0, 3'h1), 4'h0);
    send(14'h000C, cmd(8'h01, 4'h0, 1'b1, 1'b1, 5'h03, 4'h4, 3'h1), 4'h0);
    chk_hdr({8'h01, 4'h1, 1'b1, 3'h1, 14'h000C});
    chk_hdr({8'h00, 4'h2, 1'b1, 3'h1, 14'h0010});
    chk_hdr({8'h01, 4'h1, 1'b1, 3'h1, 14'h0010});
    chk(i_node.seq_q.size(), 32'h3);
    chk({28'h0, i_node.seq_q[2]}, {28'h0, i_node.seq_q[0] + 4'h1});
    stall <= 1'b0;
  endtask

  // Reset for three cycles, then the scenarios in turn.
  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0;
    stall   = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_ts_block();
    t_window();
    t_full();
    t_generic();
    t_mix();
    results();
  end
endmodule : pptr_core_tx_tb
